// File: two_wire_defs.svh
// offsets, field positions, reset values and timing counts of the two-wire master
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH
// Summary of operation
// - receive-full raises interrupt while bit 6 set
// - transmit-empty bit 3 set after byte sent
// - writing transmit byte clears transmit-empty
// - vector write cancels transmit and receive interrupts, flags stay
// - stop-on-read bit 1 stops after current byte
// - stop-on-write bit 0 stops after current byte
// - receive byte register holds latest received byte
`define TW_ADDR_CTL 16'hffc0
`define TW_ADDR_TXD 16'hffc1
`define TW_ADDR_RXD 16'hffc2
`define TW_ADDR_SLA 16'hffc3
`define TW_ADDR_VEC 16'hffb2
`define TW_BIT_RXF 7
`define TW_BIT_RECEIVE_IRQ_ENABLE 6
`define TW_BIT_ERR 5
`define TW_BIT_FRQ 4
`define TW_BIT_TXE 3
`define TW_BIT_TRANSMIT_IRQ_ENABLE 2
`define TW_BIT_STOP_AFTER_READ_BYTE 1
`define TW_BIT_STOP_AFTER_WRITE_BYTE 0
`define TW_CTL_RESET 8'h00
`define TW_CLK_NS 50
`define TW_SLOW_HALF_NS 5000
`define TW_FAST_HALF_NS 1250
`define TW_SLOW_HALF_CYC ((`TW_SLOW_HALF_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_FAST_HALF_CYC ((`TW_FAST_HALF_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`endif

// File: two_wire_pkg.sv
// types of the two-wire master
package two_wire_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_START = 4'h1,
		ST_BIT = 4'h2,
		ST_ACK = 4'h3,
		ST_WAIT = 4'h4,
		ST_STOP = 4'h5,
		ST_RSTART = 4'h6
	} tw_state_t;
endpackage

// File: two_wire_master.sv
// two-wire master with control and status register
`timescale 1ns/1ns
`include "two_wire_defs.svh"
module two_wire_master #(
	parameter int SLOW_HALF = `TW_SLOW_HALF_CYC,
	parameter int FAST_HALF = `TW_FAST_HALF_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic irqOut,
	input wire logic sclIn,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOe
);
	// refuse half periods that the 16-bit divider cannot count
	if (SLOW_HALF < 2 || FAST_HALF < 2 || SLOW_HALF > 65535 || FAST_HALF > 65535) begin
		$error("half period out of range");
	end

	// ============================
	// pin synchronisers
	logic [1:0] sdaSync_q, sclSync_q;
	always_ff @(posedge clk) begin
		sdaSync_q <= {sdaSync_q[0], sdaIn};
		sclSync_q <= {sclSync_q[0], sclIn};
	end
	logic sdaS;
	logic sclS;
	assign sdaS = sdaSync_q[1];
	assign sclS = sclSync_q[1];

	// ============================
	// registers and state
	logic [7:0] ctl_q, ctl_d, txd_q, txd_d, rxd_q, rxd_d, sla_q, sla_d, sh_q, sh_d, rd_q, rd_d;
	logic txIrq_q, txIrq_d, rxIrq_q, rxIrq_d, txPend_q, txPend_d, irq_q, irq_d;
	logic sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, phase_q, phase_d, addrPh_q, addrPh_d;
	logic rdMode_q, rdMode_d, needRs_q, needRs_d, active_q, active_d;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [15:0] div_q, div_d;
	two_wire_pkg::tw_state_t st_q, st_d;
	logic tick;
	assign tick = (div_q == 16'h0000);

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction

	// next-state logic for registers and bus engine
	always_comb begin
		ctl_d = ctl_q;
		txd_d = txd_q;
		rxd_d = rxd_q;
		sla_d = sla_q;
		sh_d = sh_q;
		rd_d = rd_q;
		txIrq_d = txIrq_q;
		rxIrq_d = rxIrq_q;
		txPend_d = txPend_q;
		sclOe_d = sclOe_q;
		sdaOe_d = sdaOe_q;
		phase_d = phase_q;
		addrPh_d = addrPh_q;
		rdMode_d = rdMode_q;
		needRs_d = needRs_q;
		active_d = active_q;
		bitCnt_d = bitCnt_q;
		st_d = st_q;
		div_d = tick ? (ctl_q[`TW_BIT_FRQ] ? 16'(FAST_HALF - 1) : 16'(SLOW_HALF - 1)) : div_q - 16'h0001;
		// processor side: reads and writes
		if (regRd && hit(regAddr, `TW_ADDR_RXD)) begin
			ctl_d[`TW_BIT_RXF] = 1'b0;
			rxIrq_d = 1'b0;
		end
		if (regWr && hit(regAddr, `TW_ADDR_CTL)) begin
			ctl_d[6:4] = regWdata[6:4];
			ctl_d[2:0] = regWdata[2:0];
		end
		if (regWr && hit(regAddr, `TW_ADDR_SLA))
			sla_d = regWdata;
		if (regWr && hit(regAddr, `TW_ADDR_TXD)) begin
			txd_d = regWdata;
			txPend_d = 1'b1;
			ctl_d[`TW_BIT_TXE] = 1'b0;
			txIrq_d = 1'b0;
		end
		if (regWr && hit(regAddr, `TW_ADDR_VEC)) begin
			txIrq_d = 1'b0;
			rxIrq_d = 1'b0;
		end
		// bus engine, one step per half period
		if (tick) begin
			case (st_q)
				two_wire_pkg::ST_IDLE: begin
					sclOe_d = 1'b0;
					sdaOe_d = 1'b0;
					if (txPend_q && !active_q) begin
						// first byte is the address with a write direction
						sh_d = {sla_q[7:1], 1'b0};
						addrPh_d = 1'b1;
						rdMode_d = 1'b0;
						needRs_d = sla_q[0];
						sdaOe_d = 1'b1;
						st_d = two_wire_pkg::ST_START;
					end
				end
				two_wire_pkg::ST_START: begin
					sclOe_d = 1'b1;
					active_d = 1'b1;
					bitCnt_d = 3'h7;
					phase_d = 1'b0;
					st_d = two_wire_pkg::ST_BIT;
				end
				two_wire_pkg::ST_BIT: begin
					// data moves only under a low clock, one step before the clock is released
					if (!phase_q) begin
						sdaOe_d = rdMode_q ? 1'b0 : ~sh_q[7];
						phase_d = 1'b1;
					end else if (sclOe_q) begin
						sclOe_d = 1'b0;
					end else if (sclS) begin
						rd_d = {rd_q[6:0], sdaS};
						sh_d = {sh_q[6:0], 1'b0};
						sclOe_d = 1'b1;
						phase_d = 1'b0;
						bitCnt_d = bitCnt_q - 3'h1;
						if (bitCnt_q == 3'h0)
							st_d = two_wire_pkg::ST_ACK;
					end
				end
				two_wire_pkg::ST_ACK: begin
					if (!phase_q) begin
						// master acks read bytes unless a stop follows the byte
						sdaOe_d = rdMode_q && !ctl_q[`TW_BIT_STOP_AFTER_READ_BYTE];
						phase_d = 1'b1;
					end else if (sclOe_q) begin
						sclOe_d = 1'b0;
					end else if (sclS) begin
						sclOe_d = 1'b1;
						phase_d = 1'b0;
						if (!rdMode_q && sdaS) begin
							ctl_d[`TW_BIT_ERR] = 1'b1;
							st_d = two_wire_pkg::ST_STOP;
						end else if (rdMode_q) begin
							rxd_d = rd_q;
							ctl_d[`TW_BIT_RXF] = 1'b1;
							rxIrq_d = 1'b1;
							st_d = ctl_q[`TW_BIT_STOP_AFTER_READ_BYTE] ? two_wire_pkg::ST_STOP : two_wire_pkg::ST_START;
						end else if (addrPh_q) begin
							addrPh_d = 1'b0;
							st_d = two_wire_pkg::ST_WAIT;
						end else begin
							txPend_d = 1'b0;
							ctl_d[`TW_BIT_TXE] = 1'b1;
							txIrq_d = 1'b1;
							st_d = ctl_q[`TW_BIT_STOP_AFTER_WRITE_BYTE] ? two_wire_pkg::ST_STOP : two_wire_pkg::ST_WAIT;
						end
					end
				end
				two_wire_pkg::ST_WAIT: begin
					// hold the clock low until the next byte is ready
					if (needRs_q && !txPend_q) begin
						sdaOe_d = 1'b0;
						sclOe_d = 1'b0;
						st_d = two_wire_pkg::ST_RSTART;
					end else if (txPend_q && !txIrq_q) begin
						sh_d = txd_q;
						st_d = two_wire_pkg::ST_START;
						bitCnt_d = 3'h7;
						sclOe_d = 1'b1;
						sdaOe_d = 1'b1;
						phase_d = 1'b0;
						st_d = two_wire_pkg::ST_BIT;
					end
				end
				two_wire_pkg::ST_RSTART: begin
					// repeated start, then address with read direction
					sdaOe_d = 1'b1;
					sh_d = {sla_q[7:1], 1'b1};
					needRs_d = 1'b0;
					addrPh_d = 1'b1;
					st_d = two_wire_pkg::ST_START;
					if (addrPh_q == 1'b0 && bitCnt_q == 3'h7 && sh_q == {sla_q[7:1], 1'b1})
						rdMode_d = 1'b1;
				end
				two_wire_pkg::ST_STOP: begin
					// stop: pull data low under the low clock, release clock, then data
					if (sclOe_q && !sdaOe_q) begin
						sdaOe_d = 1'b1;
					end else if (sclOe_q) begin
						sclOe_d = 1'b0;
					end else begin
						sdaOe_d = 1'b0;
						active_d = 1'b0;
						rdMode_d = 1'b0;
						txPend_d = 1'b0;
						ctl_d[`TW_BIT_STOP_AFTER_READ_BYTE] = 1'b0;
						ctl_d[`TW_BIT_STOP_AFTER_WRITE_BYTE] = 1'b0;
						st_d = two_wire_pkg::ST_IDLE;
					end
				end
				default: st_d = two_wire_pkg::ST_IDLE;
			endcase
			// after the read address is acknowledged, receive data bytes
			if (st_q == two_wire_pkg::ST_ACK && phase_q && !sclOe_q && sclS && !sdaS && addrPh_q && needRs_q == 1'b0
				&& sla_q[0]) begin
				rdMode_d = 1'b1;
				addrPh_d = 1'b0;
				st_d = two_wire_pkg::ST_START;
			end
		end
		irq_d = (rxIrq_d && ctl_d[`TW_BIT_RECEIVE_IRQ_ENABLE]) || (txIrq_d && ctl_d[`TW_BIT_TRANSMIT_IRQ_ENABLE]);
	end

	// register update
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctl_q <= `TW_CTL_RESET;
			txd_q <= 8'h00;
			rxd_q <= 8'h00;
			sla_q <= 8'h00;
			sh_q <= 8'h00;
			rd_q <= 8'h00;
			txIrq_q <= 1'b0;
			rxIrq_q <= 1'b0;
			txPend_q <= 1'b0;
			irq_q <= 1'b0;
			sclOe_q <= 1'b0;
			sdaOe_q <= 1'b0;
			phase_q <= 1'b0;
			addrPh_q <= 1'b0;
			rdMode_q <= 1'b0;
			needRs_q <= 1'b0;
			active_q <= 1'b0;
			bitCnt_q <= 3'h7;
			div_q <= 16'h0000;
			st_q <= two_wire_pkg::ST_IDLE;
		end else begin
			ctl_q <= ctl_d;
			txd_q <= txd_d;
			rxd_q <= rxd_d;
			sla_q <= sla_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			txIrq_q <= txIrq_d;
			rxIrq_q <= rxIrq_d;
			txPend_q <= txPend_d;
			irq_q <= irq_d;
			sclOe_q <= sclOe_d;
			sdaOe_q <= sdaOe_d;
			phase_q <= phase_d;
			addrPh_q <= addrPh_d;
			rdMode_q <= rdMode_d;
			needRs_q <= needRs_d;
			active_q <= active_d;
			bitCnt_q <= bitCnt_d;
			div_q <= div_d;
			st_q <= st_d;
		end
	end

	// registered read data
	always_ff @(posedge clk) begin
		if (sys_rst)
			regRdata <= 8'h00;
		else if (hit(regAddr, `TW_ADDR_CTL))
			regRdata <= ctl_q;
		else if (hit(regAddr, `TW_ADDR_RXD))
			regRdata <= rxd_q;
		else if (hit(regAddr, `TW_ADDR_SLA))
			regRdata <= sla_q;
		else
			regRdata <= 8'h00; // transmit byte is write only
	end

	assign irqOut = irq_q;
	assign sclOe = sclOe_q;
	assign sdaOe = sdaOe_q;
endmodule

// File: two_wire_master_monitor.sv
// assertions on the ports of the two-wire master
`timescale 1ns/1ns
module two_wire_master_monitor #(
	parameter int SLOW_HALF = 8,
	parameter int FAST_HALF = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic irqOut,
	input wire logic sclIn,
	input wire logic sclOe,
	input wire logic sdaIn,
	input wire logic sdaOe
);
	logic [1:0] irqEn_q, irqEn_d;
	logic started_q, started_d, atCtl;
	assign atCtl = regAddr == 16'hffc0;
	// ====
	// follow the interrupt enables and the first transfer request
	always_comb begin
		irqEn_d = (regWr && atCtl) ? {regWdata[6], regWdata[2]} : irqEn_q;
		started_d = started_q || (regWr && regAddr == 16'hffc1);
	end
	always_ff @(posedge clk) begin
		irqEn_q <= sys_rst ? 2'h0 : irqEn_d;
		started_q <= sys_rst ? 1'b0 : started_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_flags_sticky: assert property ((atCtl && !regWr)[*2]
		|=> !$fell(regRdata[7]) && !$fell(regRdata[5]) && !$fell(regRdata[3])) else $error("flag dropped");
	a_rx_read_clr: assert property (regRd && regAddr == 16'hffc2 ##[1:2] atCtl |=> !regRdata[7])
		else $error("rx flag kept");
	a_tx_write_clr: assert property (regWr && regAddr == 16'hffc1 ##[1:2] atCtl |=> !regRdata[3])
		else $error("tx flag kept");
	a_vec_clr_irq: assert property (regWr && regAddr == 16'hffb2 |-> ##2 !irqOut) else $error("irq kept");
	a_irq_masked: assert property (irqEn_d == 2'h0 |=> !irqOut) else $error("irq unmasked");
	a_wo_reads_zero: assert property (regAddr == 16'hffc1 || regAddr == 16'hffb2 || regAddr == 16'h0
		|=> regRdata == 8'h00) else $error("nonzero read");
	a_scl_low_min: assert property ($rose(sclOe) |=> sclOe[*3]) else $error("short clock");
	a_idle_before: assert property (!started_q |-> !sclOe && !sdaOe) else $error("early drive");
endmodule
bind two_wire_master two_wire_master_monitor #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF))
	two_wire_master_monitor_inst (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr),
	.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .irqOut(irqOut), .sclIn(sclIn),
	.sclOe(sclOe), .sdaIn(sdaIn), .sdaOe(sdaOe));

// File: two_wire_slave_model.sv
// behavioural two-wire slave: acknowledges, keeps written data, returns it
`timescale 1ns/1ns
module two_wire_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	output logic pull
);
	logic [7:0] sh = 8'h00, mem = 8'h00;
	int n = 0, k = 0;
	logic rd = 1'b0, go = 1'b0;
	initial pull = 1'b0;
	// ====
	// start resets the counts
	always @(negedge sda) if (scl) begin
		n = 0;
		k = 0;
		pull = 1'b0;
	end
	// sample data and acknowledge on the rising clock
	always @(posedge scl) begin
		if (n < 8) sh = {sh[6:0], sda};
		if (n == 8) go = !sda;
		n++;
	end
	// change the line only while the clock is low
	always @(negedge scl) begin
		if (n == 8) begin
			if (k == 0) rd = sh[0];
			if (!rd && k > 1) mem = sh;
			pull = !(rd && k > 0) && !nack;
		end else if (n == 9) begin
			n = 0;
			k++;
			pull = rd && go && !mem[7];
		end else if (rd && k > 0 && n > 0) begin
			pull = go && !mem[7 - n];
		end
	end
endmodule

// File: two_wire_master_ctl_status_tb.sv
// self-checking bench for the two-wire master control and status logic
`timescale 1ns/1ns
module two_wire_master_ctl_status_tb;
	logic clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, nack = 1'b0, seen = 1'b0;
	logic [15:0] regAddr = 16'h0000, e;
	logic [7:0] regWdata = 8'h00, regRdata, d, sa;
	logic irqOut, sclOe, sdaOe, pull;
	logic [15:0] expQ[$];
	int error_cnt = 0, tests_run = 0, cyc = 0;
	wire scl = !sclOe;
	wire sda = !(sdaOe || pull);
	// ====
	// design and slave on a pulled-up bus
	two_wire_master #(.SLOW_HALF(8), .FAST_HALF(4)) two_wire_master_inst (.clk(clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
		.irqOut(irqOut), .sclIn(scl), .sclOe(sclOe), .sdaIn(sda), .sdaOe(sdaOe));
	two_wire_slave_model two_wire_slave_model_inst (.scl(scl), .sda(sda), .nack(nack), .pull(pull));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic c, input string m);
		tests_run++;
		if (c !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task final_report;
		$display("mismatches %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back({m, x});
		@(posedge clk);
		regRd <= 1'b0;
	endtask
	task automatic poll(input int b, input logic v);
		int i;
		@(posedge clk);
		regAddr <= 16'hffc0;
		repeat (2) @(negedge clk);
		for (i = 0; i < 3000 && regRdata[b] !== v; i++) @(negedge clk);
		chk(i < 3000, "poll");
	endtask
	// compare each read answer with the oldest note
	always @(negedge clk) begin
		if (seen) begin
			e = expQ.pop_front();
			chk((regRdata & e[15:8]) === e[7:0], "read");
		end
		seen = regRd;
	end
	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			chk(1'b0, "timeout");
			final_report;
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'hf969af6d));
		d = 8'($urandom);
		sa = 8'($urandom);
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(16'hffc0, 8'hff, 8'h00);
		rd(16'h0000, 8'hff, 8'h00);
		wr(16'hffc0, 8'hdc);
		rd(16'hffc0, 8'hdc, 8'h54);
		wr(16'hffc0, 8'h04);
		wr(16'hffc3, {sa[6:0], 1'b0});
		wr(16'hffc1, 8'h10);
		poll(3, 1'b1);
		@(negedge clk);
		chk(irqOut, "tx irq");
		wr(16'hffb2, 8'h00);
		rd(16'hffc0, 8'h08, 8'h08);
		chk(!irqOut, "irq kept");
		wr(16'hffc0, 8'h05);
		wr(16'hffc1, d);
		rd(16'hffc0, 8'h08, 8'h00);
		poll(3, 1'b1);
		poll(0, 1'b0);
		chk(!sclOe && !sdaOe, "no stop");
		wr(16'hffc0, 8'h52);
		wr(16'hffc3, {sa[6:0], 1'b1});
		wr(16'hffc1, 8'h10);
		poll(7, 1'b1);
		@(negedge clk);
		chk(irqOut, "rx irq");
		rd(16'hffc2, 8'hff, d);
		rd(16'hffc0, 8'h80, 8'h00);
		poll(1, 1'b0);
		chk(!sclOe && !sdaOe, "no stop");
		wr(16'hffc0, 8'h00);
		nack <= 1'b1;
		wr(16'hffc3, {sa[6:0], 1'b0});
		wr(16'hffc1, 8'h10);
		poll(5, 1'b1);
		rd(16'hffc0, 8'h20, 8'h20);
		wr(16'hffc0, 8'h00);
		rd(16'hffc0, 8'h20, 8'h00);
		repeat (2) @(posedge clk);
		final_report;
	end
endmodule
